/* File: rtl/cmr_core.sv */
// executor for move, no-operation and return instructions with file and call stack
`include "cmr_defines.svh"
`default_nettype none
module cmr_core
  import cmr_pkg::*;
(
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst_b,
  // instruction issue
  input  wire logic        instr_valid,
  output logic             instr_ready,
  input  wire cmr_op_t     instr_op,
  input  wire logic [5:0]  file_addr,
  input  wire logic        dest_bit,
  input  wire logic [7:0]  literal,
  // stack push from the call logic
  input  wire logic        push_en,
  input  wire logic [9:0]  push_addr,
  // state
  output logic [7:0]       accumulator,
  output logic [9:0]       pc,
  output logic             zero_flag,
  output logic             global_irq_enable,
  output logic [3:0]       stack_level,
  output logic [7:0]       file_peek_data,
  input  wire logic [5:0]  file_peek_addr
);
  logic [7:0]  file_r [`CMR_FILE_N];
  logic [9:0]  stack_r [`CMR_STK_DEPTH];
  logic [7:0]  acc_r;
  logic [9:0]  pc_r;
  logic        zero_r;
  logic        gie_r;
  logic [3:0]  lvl_r;
  logic [7:0]  peek_r;
  cmr_state_t  state_r;
  logic [1:0]  cyc_r;
  logic        go;
  logic        is_ret;
  logic [7:0]  file_val;
  logic [9:0]  tos;

  assign instr_ready = (state_r == CMR_ST_EXEC);
  assign go          = instr_valid && instr_ready;
  assign is_ret      = (instr_op == CMR_OP_RLIT) || (instr_op == CMR_OP_RIRQ);
  assign file_val    = file_r[file_addr];
  assign tos         = (lvl_r == 4'h0) ? `CMR_PC_RST : stack_r[lvl_r[2:0] - 3'h1];
  assign accumulator = acc_r;
  assign pc          = pc_r;
  assign zero_flag   = zero_r;
  assign global_irq_enable = gie_r;
  assign stack_level = lvl_r;
  assign file_peek_data = peek_r;

  // second cycle of a return is a flush cycle
  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      state_r <= CMR_ST_EXEC;
      cyc_r   <= 2'h0;
    end
    else
    begin
      case (state_r)
        CMR_ST_EXEC:
        begin
          if (go && is_ret)
          begin
            state_r <= CMR_ST_FLUSH;
            cyc_r   <= 2'h1;
          end
        end
        CMR_ST_FLUSH:
        begin
          cyc_r <= cyc_r + 2'h1;
          if (cyc_r + 2'h1 == `CMR_RET_CYC)
          begin
            state_r <= CMR_ST_EXEC;
            cyc_r   <= 2'h0;
          end
        end
        default:
        begin
          state_r <= CMR_ST_EXEC;
        end
      endcase
    end
  end

  // data file: no reset, written by the two moves
  always_ff @(posedge sys_clk)
  begin
    if (go && instr_op == CMR_OP_MAF)
      file_r[file_addr] <= acc_r;
    else if (go && instr_op == CMR_OP_MFD && dest_bit)
      file_r[file_addr] <= file_val;
    peek_r <= file_r[file_peek_addr];
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
      acc_r <= `CMR_ACC_RST;
    else if (go && instr_op == CMR_OP_MFD && !dest_bit)
      acc_r <= file_val;
    else if (go && instr_op == CMR_OP_RLIT)
      acc_r <= literal;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
      zero_r <= 1'b0;
    else if (go && instr_op == CMR_OP_MFD)
      zero_r <= (file_val == 8'h00);
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
      gie_r <= 1'b0;
    else if (go && is_ret)
      gie_r <= 1'b1;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
      pc_r <= `CMR_PC_RST;
    else if (go && is_ret)
      pc_r <= tos;
    else if (go)
      pc_r <= pc_r + 10'h001;
  end

  // stack: pushes from the call logic, pops on returns; empty pop stays at zero
  // a push that meets a taken return is dropped, so level and entries stay in step
  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
      lvl_r <= 4'h0;
    else if (go && is_ret && lvl_r != 4'h0)
      lvl_r <= lvl_r - 4'h1;
    else if (push_en && lvl_r != 4'h8 && !(go && is_ret))
      lvl_r <= lvl_r + 4'h1;
  end

  always_ff @(posedge sys_clk)
  begin
    if (push_en && lvl_r != 4'h8 && !(go && is_ret))
      stack_r[lvl_r[2:0]] <= push_addr;
  end

  // checks
  sequence ret_taken_s;
    go && is_ret;
  endsequence

  sequence flush_one_s;
    !instr_ready ##1 instr_ready;
  endsequence

  sequence mfd_taken_s;
    go && instr_op == CMR_OP_MFD;
  endsequence

  maf_writes_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    go && instr_op == CMR_OP_MAF ##1 1'b1 |-> file_r[$past(file_addr)] == $past(acc_r))
    else $error("file not loaded from accumulator");
  maf_flags_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    go && instr_op == CMR_OP_MAF |=> $stable(zero_r) && $stable(acc_r))
    else $error("accumulator move changed state");
  mfd_acc_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    go && instr_op == CMR_OP_MFD && !dest_bit |=> acc_r == $past(file_val))
    else $error("file not moved to accumulator");
  mfd_zero_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    go && instr_op == CMR_OP_MFD |=> zero_r == ($past(file_val) == 8'h00))
    else $error("zero flag wrong after file move");
  rlit_acc_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    go && instr_op == CMR_OP_RLIT |=> acc_r == $past(literal) && $stable(zero_r))
    else $error("literal return accumulator wrong");
  ret_two_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    ret_taken_s |=> flush_one_s)
    else $error("return not two cycles");
  ret_gie_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    ret_taken_s |=> gie_r)
    else $error("global enable not set on return");
  rirq_pc_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    go && instr_op == CMR_OP_RIRQ |=> pc_r == $past(tos) && $stable(acc_r))
    else $error("interrupt return pc wrong");
  ret_pop_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (ret_taken_s and (lvl_r != 4'h0)) |=> lvl_r == $past(lvl_r) - 4'h1)
    else $error("stack not popped");
  nop_step_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    go && instr_op == CMR_OP_NOP |=> pc_r == $past(pc_r) + 10'h001 && $stable(acc_r) && $stable(zero_r))
    else $error("no-operation changed state");

  // timing, write-back, flag, stack and flush checks
  maf_step_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    go && instr_op == CMR_OP_MAF |=> instr_ready && pc_r == $past(pc_r) + 10'h001)
    else $error("accumulator move not one cycle");
  mfd_back_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (mfd_taken_s and dest_bit) |=> file_r[$past(file_addr)] == $past(file_val) && $stable(acc_r))
    else $error("file move back to register wrong");
  mfd_step_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    mfd_taken_s |=> instr_ready)
    else $error("file move not one cycle");
  ret_flags_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    ret_taken_s |=> $stable(zero_r))
    else $error("return changed zero flag");
  ret_pc_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    ret_taken_s |=> pc_r == $past(tos))
    else $error("popped entry not loaded into pc");
  empty_pop_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (ret_taken_s and (lvl_r == 4'h0)) |=> lvl_r == 4'h0 && pc_r == `CMR_PC_RST)
    else $error("return on empty stack wrong");
  flush_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !instr_ready |=> $stable(acc_r) && $stable(pc_r) && $stable(zero_r) && $stable(gie_r))
    else $error("state changed in flush cycle");
  nop_step_one_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    go && instr_op == CMR_OP_NOP |=> instr_ready)
    else $error("no-operation not one cycle");
endmodule
`default_nettype wire

/* File: rtl/cmr_defines.svh */
// constants of the move and return instruction executor
// Contract
// - accumulator copied to file register 0..63, one cycle
// - file read into accumulator or back to itself
// - file move sets zero flag from moved value
// - literal return loads accumulator, pops PC, two cycles
// - literal return sets global interrupt enable
// - interrupt return pops PC, sets enable, two cycles
// - each return pops stack, level drops one unless already zero, where it stays at zero
`ifndef CMR_DEFINES_SVH
`define CMR_DEFINES_SVH
`define CMR_PC_W       10
`define CMR_STK_DEPTH  8
`define CMR_LVL_W      4
`define CMR_FILE_N     64
`define CMR_ACC_RST    8'h00
`define CMR_PC_RST     10'h000
`define CMR_RET_CYC    2'h2
`endif

/* File: rtl/cmr_pkg.sv */
// types of the move and return instruction executor
`default_nettype none
package cmr_pkg;
  typedef enum logic [2:0]
  {
    CMR_OP_NOP  = 3'b000,
    CMR_OP_MAF  = 3'b001,
    CMR_OP_MFD  = 3'b010,
    CMR_OP_RLIT = 3'b011,
    CMR_OP_RIRQ = 3'b100
  } cmr_op_t;
  typedef enum logic [0:0]
  {
    CMR_ST_EXEC = 1'b0,
    CMR_ST_FLUSH = 1'b1
  } cmr_state_t;
endpackage
`default_nettype wire

/* File: tb/cmr_core_tb.sv */
// self-checking bench of the move and return instruction executor
`default_nettype none
module cmr_core_tb
  import cmr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic       sys_clk = 1'b0;
  logic       rst_b = 1'b0;
  logic       instr_valid = 1'b0;
  logic       instr_ready;
  cmr_op_t    instr_op = CMR_OP_NOP;
  logic [5:0] file_addr = 6'h00;
  logic       dest_bit = 1'b0;
  logic [7:0] literal = 8'h00;
  logic       push_en = 1'b0;
  logic [9:0] push_addr = 10'h000;
  logic [7:0] accumulator;
  logic [9:0] pc;
  logic       zero_flag;
  logic       global_irq_enable;
  logic [3:0] stack_level;
  logic [7:0] file_peek_data;
  logic [5:0] file_peek_addr = 6'h00;
  int         errors = 0;
  int         check_count = 0;
  cmr_core i_cmr_core (.sys_clk(sys_clk), .rst_b(rst_b), .instr_valid(instr_valid), .instr_ready(instr_ready),
    .instr_op(instr_op), .file_addr(file_addr), .dest_bit(dest_bit), .literal(literal), .push_en(push_en),
    .push_addr(push_addr), .accumulator(accumulator), .pc(pc), .zero_flag(zero_flag),
    .global_irq_enable(global_irq_enable), .stack_level(stack_level), .file_peek_data(file_peek_data),
    .file_peek_addr(file_peek_addr));
  initial
  begin
    forever #5 sys_clk = ~sys_clk;
  end
  task automatic summarize();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input string name, input logic [9:0] exp, input logic [9:0] seen);
    check_count++;
    if (seen !== exp)
    begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic reset_core();
    @(posedge sys_clk);
    rst_b <= 1'b0;
    repeat (6) @(posedge sys_clk);
    rst_b <= 1'b1;
  endtask
  // offer one instruction, hold it until ready, return just after the taking edge
  task automatic issue(input cmr_op_t op, input logic [5:0] a, input logic d, input logic [7:0] lit);
    int n;
    n = 0;
    @(posedge sys_clk);
    instr_op <= op;
    file_addr <= a;
    dest_bit <= d;
    literal <= lit;
    instr_valid <= 1'b1;
    @(negedge sys_clk);
    while (instr_ready !== 1'b1)
    begin
      n++;
      if (n > 20)
      begin
        errors++;
        summarize();
      end
      @(negedge sys_clk);
    end
    @(posedge sys_clk);
    instr_valid <= 1'b0;
    #1;
  endtask
  task automatic push(input logic [9:0] a);
    @(posedge sys_clk);
    push_en <= 1'b1;
    push_addr <= a;
    @(posedge sys_clk);
    push_en <= 1'b0;
  endtask
  task automatic peek(input logic [5:0] a, input logic [7:0] exp);
    @(posedge sys_clk);
    file_peek_addr <= a;
    repeat (2) @(posedge sys_clk);
    #1;
    chk("file", {2'h0, exp}, {2'h0, file_peek_data});
  endtask
  task automatic t_move_acc();
    issue(CMR_OP_RLIT, 6'h00, 1'b0, 8'hA5);
    chk("acc", 10'h0A5, {2'h0, accumulator});
    issue(CMR_OP_MAF, 6'h3F, 1'b0, 8'h00);
    chk("zero", 10'h000, {9'h0, zero_flag});
    peek(6'h3F, 8'hA5);
  endtask
  task automatic t_move_file();
    issue(CMR_OP_RLIT, 6'h00, 1'b0, 8'h00);
    issue(CMR_OP_MAF, 6'h05, 1'b0, 8'h00);
    issue(CMR_OP_RLIT, 6'h00, 1'b0, 8'h3C);
    issue(CMR_OP_MFD, 6'h05, 1'b0, 8'h00);
    chk("acc", 10'h000, {2'h0, accumulator});
    chk("zero", 10'h001, {9'h0, zero_flag});
    issue(CMR_OP_MFD, 6'h3F, 1'b1, 8'h00);
    chk("zero", 10'h000, {9'h0, zero_flag});
    chk("acc", 10'h000, {2'h0, accumulator});
    peek(6'h3F, 8'hA5);
  endtask
  task automatic t_returns();
    reset_core();
    push(10'h123);
    push(10'h2A0);
    issue(CMR_OP_RLIT, 6'h00, 1'b0, 8'h7E);
    chk("ready", 10'h000, {9'h0, instr_ready});
    chk("pc", 10'h2A0, pc);
    chk("gie", 10'h001, {9'h0, global_irq_enable});
    chk("level", 10'h001, {6'h0, stack_level});
    reset_core();
    push(10'h0F1);
    issue(CMR_OP_RIRQ, 6'h00, 1'b0, 8'h5A);
    chk("ready", 10'h000, {9'h0, instr_ready});
    chk("pc", 10'h0F1, pc);
    chk("gie", 10'h001, {9'h0, global_irq_enable});
    chk("level", 10'h000, {6'h0, stack_level});
    chk("acc", 10'h000, {2'h0, accumulator});
  endtask
  task automatic t_nop();
    issue(CMR_OP_NOP, 6'h00, 1'b0, 8'hC3);
    chk("pc", 10'h0F2, pc);
    chk("acc", 10'h000, {2'h0, accumulator});
  endtask
  initial
  begin
    reset_core();
    t_move_acc();
    t_move_file();
    t_returns();
    t_nop();
    summarize();
  end
endmodule
`default_nettype wire
